// *** ca_defines.svh ***
// constants of the counter array compare/capture block
`ifndef CA_DEFINES_SVH
`define CA_DEFINES_SVH

// -----------------------------------------------------------------
// sizes
// -----------------------------------------------------------------
`define CA_NMOD 5
`define CA_WD_MODULE 4

// -----------------------------------------------------------------
// register addresses
// -----------------------------------------------------------------
`define CA_CTRL_ADDR 8'hD8
`define CA_CMODE_ADDR 8'hD9
`define CA_MODE_BASE 8'hDA
`define CA_CL_ADDR 8'hE9
`define CA_CAPL_BASE 8'hEA
`define CA_CH_ADDR 8'hF9
`define CA_CAPH_BASE 8'hFA

// -----------------------------------------------------------------
// module mode register fields
// -----------------------------------------------------------------
`define CA_B_COMPARATOR_ENABLE 6
`define CA_B_CAPTURE_RISING 5
`define CA_B_CAPTURE_FALLING 4
`define CA_B_MAT 3
`define CA_B_TOG 2
`define CA_B_PWM 1
`define CA_B_ECCF 0
`define CA_MODE_MASK 8'h7F

// -----------------------------------------------------------------
// counter control and counter mode fields
// -----------------------------------------------------------------
`define CA_B_RUN 6
`define CA_B_ARRAY_WATCHDOG_ENABLE 6
`define CA_TPS_MSB 3
`define CA_TPS_LSB 0
`define CA_CPS_MSB 5
`define CA_CPS_LSB 4
`define CA_CPS_SYSCLK 2'h0

// -----------------------------------------------------------------
// values
// -----------------------------------------------------------------
`define CA_RST_BYTE 8'h00
`define CA_BYTE_MAX 8'hFF
`define CA_RST_FLAGS 5'h00
`define CA_RST_CNT 16'h0000
`define CA_RST_PRE 4'h0

`endif

// *** ca_pkg.sv ***
// types shared by the counter array compare/capture block
package ca_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    ROLE_IDLE,
    ROLE_CAPTURE,
    ROLE_HSO,
    ROLE_PWM
  } pin_role_t;
endpackage

// *** counter_array_compare_capture.sv ***
// five compare/capture modules on one shared 16-bit counter
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "ca_defines.svh"

// How it works
// R1 - capture mode whenever capture-falling or capture-rising bit is set
// R2 - valid enabled pin edge copies counter into module compare registers
// R3 - interrupt only while module event flag and its irq enable are set
// R4 - comparator and match enables on: counter equality sets event flag
// R5 - writing compare high byte sets comparator enable
// R6 - writing compare low byte clears comparator enable when set
// R7 - software loads non-zero compares, low byte first then high byte
// R8 - comparator enable stays readable and writable in mode register
// R9 - high-speed output inverts pin on each counter match
// R10 - high-speed output needs toggle, match and comparator enables set
// R11 - all modules may do PWM; shared counter gives common frequency
// R12 - PWM pin low while counter low below compare low, else high
// R13 - on counter low wrap, compare low reloads from compare high
// R14 - PWM needs both PWM bit and comparator enable set
// R15 - counter steps at system clock over prescale plus one, source zero
// R16 - only module four has the watchdog; otherwise usable normally
// R17 - watchdog compares 16-bit value with shared counter like compare
// R18 - watchdog match gives internal reset, never drives reset pin
// R19 - clearing array watchdog enable blocks reset, setting re-arms
// R20 - software defers watchdog by moving compare ahead of counter
// R21 - mode bits: 6 comp, 5 rise, 4 fall, 3 match, 2 tog, 1 pwm, 0 irq
// R22 - both edge bits set: capture on either transition
// R23 - pins synchronised by flip-flops, edges from successive samples
// R24 - match evaluated once per counter change, acts only once
module counter_array_compare_capture
  import ca_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic [`CA_NMOD-1:0] MOD_PIN_I,
  output logic [`CA_NMOD-1:0] MOD_PIN_O,
  output logic [`CA_NMOD-1:0] MOD_PIN_OE_O,
  output logic IRQ_O,
  output logic INT_RST_O
);

  // -----------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int i);
    return a == (base + 8'(i));
  endfunction

  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < (base + 8'(`CA_NMOD)));
  endfunction

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  byte_t mode_q [`CA_NMOD];
  byte_t capl_q [`CA_NMOD];
  byte_t caph_q [`CA_NMOD];
  byte_t cmode_q;
  byte_t rdata_q;
  logic [`CA_NMOD-1:0] flag_q;
  logic run_q;
  logic [15:0] cnt_q;
  logic [3:0] pre_q;
  logic upd_q;
  logic [`CA_NMOD-1:0] s1_q, s2_q, s3_q, stab_q;
  logic [`CA_NMOD-1:0] pout_q;
  logic wdrst_q;

  logic [`CA_NMOD-1:0] wr_mode, wr_capl, wr_caph;
  logic [`CA_NMOD-1:0] rise, fall, cap_ev, match_ev, pwm_on, hso_on, eccf;
  logic wr_ctrl, wr_cmode, wr_cl, wr_ch, tick, wrap, wd_hit;
  pin_role_t role [`CA_NMOD];

  // -----------------------------------------------------------------
  // per-module combinational decode
  // -----------------------------------------------------------------
  assign wr_ctrl = WR_I && (ADDR_I == `CA_CTRL_ADDR);
  assign wr_cmode = WR_I && (ADDR_I == `CA_CMODE_ADDR);
  assign wr_cl = WR_I && (ADDR_I == `CA_CL_ADDR);
  assign wr_ch = WR_I && (ADDR_I == `CA_CH_ADDR);
  // counter steps only from the system clock source
  assign tick = run_q && (cmode_q[`CA_CPS_MSB:`CA_CPS_LSB] == `CA_CPS_SYSCLK)
                && (pre_q == cmode_q[`CA_TPS_MSB:`CA_TPS_LSB]); // R15
  assign wrap = tick && (cnt_q[7:0] == `CA_BYTE_MAX);

  always_comb begin
    for (int i = 0; i < `CA_NMOD; i++) begin
      wr_mode[i] = WR_I && hit(ADDR_I, `CA_MODE_BASE, i);
      wr_capl[i] = WR_I && hit(ADDR_I, `CA_CAPL_BASE, i);
      wr_caph[i] = WR_I && hit(ADDR_I, `CA_CAPH_BASE, i);
      eccf[i] = mode_q[i][`CA_B_ECCF];
      rise[i] = (s2_q[i] == s3_q[i]) && s3_q[i] && !stab_q[i]; // R23
      fall[i] = (s2_q[i] == s3_q[i]) && !s3_q[i] && stab_q[i]; // R23
      cap_ev[i] = (rise[i] && mode_q[i][`CA_B_CAPTURE_RISING])
                  || (fall[i] && mode_q[i][`CA_B_CAPTURE_FALLING]); // R1 R22
      // compare only in the cycle after the counter changed
      match_ev[i] = upd_q && mode_q[i][`CA_B_COMPARATOR_ENABLE]
                    && (cnt_q == {caph_q[i], capl_q[i]}); // R24 R4 R17
      pwm_on[i] = mode_q[i][`CA_B_PWM] && mode_q[i][`CA_B_COMPARATOR_ENABLE]; // R14 R11
      hso_on[i] = mode_q[i][`CA_B_TOG] && mode_q[i][`CA_B_MAT]
                  && mode_q[i][`CA_B_COMPARATOR_ENABLE] && !mode_q[i][`CA_B_PWM]; // R10
      if (pwm_on[i]) begin
        role[i] = ROLE_PWM;
      end else if (hso_on[i]) begin
        role[i] = ROLE_HSO;
      end else if (mode_q[i][`CA_B_CAPTURE_RISING] || mode_q[i][`CA_B_CAPTURE_FALLING]) begin
        role[i] = ROLE_CAPTURE;
      end else begin
        role[i] = ROLE_IDLE;
      end
    end
  end

  // -----------------------------------------------------------------
  // shared counter and prescaler
  // -----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      pre_q <= `CA_RST_PRE;
    end else if (tick || !run_q) begin
      pre_q <= `CA_RST_PRE;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      cnt_q <= `CA_RST_CNT;
      upd_q <= 1'b0;
    end else begin
      upd_q <= tick || wr_cl || wr_ch;
      if (wr_cl) begin
        cnt_q[7:0] <= WDATA_I;
      end else if (wr_ch) begin
        cnt_q[15:8] <= WDATA_I;
      end else if (tick) begin
        cnt_q <= cnt_q + 16'h0001; // R15
      end
    end
  end

  // -----------------------------------------------------------------
  // control registers
  // -----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      run_q <= 1'b0;
      cmode_q <= `CA_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        run_q <= WDATA_I[`CA_B_RUN];
      end
      if (wr_cmode) begin
        cmode_q <= WDATA_I;
      end
    end
  end

  // hardware set wins over a software write in the same cycle
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      flag_q <= `CA_RST_FLAGS;
    end else begin
      for (int i = 0; i < `CA_NMOD; i++) begin
        flag_q[i] <= (wr_ctrl ? WDATA_I[i] : flag_q[i]) || cap_ev[i]
                     || (match_ev[i] && mode_q[i][`CA_B_MAT] && !pwm_on[i]); // R4 R2
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < `CA_NMOD; i++) begin
        mode_q[i] <= `CA_RST_BYTE;
      end
    end else begin
      for (int i = 0; i < `CA_NMOD; i++) begin
        if (wr_mode[i]) begin
          mode_q[i] <= WDATA_I & `CA_MODE_MASK; // R8 R21
        end else if (wr_caph[i]) begin
          mode_q[i][`CA_B_COMPARATOR_ENABLE] <= 1'b1; // R5
        end else if (wr_capl[i] && mode_q[i][`CA_B_COMPARATOR_ENABLE]) begin
          mode_q[i][`CA_B_COMPARATOR_ENABLE] <= 1'b0; // R6
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // compare/capture registers
  // -----------------------------------------------------------------
  // a capture outranks a software write landing in the same cycle
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < `CA_NMOD; i++) begin
        capl_q[i] <= `CA_RST_BYTE;
        caph_q[i] <= `CA_RST_BYTE;
      end
    end else begin
      for (int i = 0; i < `CA_NMOD; i++) begin
        if (cap_ev[i]) begin
          capl_q[i] <= cnt_q[7:0]; // R2
          caph_q[i] <= cnt_q[15:8]; // R2
        end else begin
          if (wr_capl[i]) begin
            capl_q[i] <= WDATA_I;
          end else if (pwm_on[i] && wrap) begin
            capl_q[i] <= caph_q[i]; // R13
          end
          if (wr_caph[i]) begin
            caph_q[i] <= WDATA_I;
          end
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // pin synchroniser and edge tracking
  // -----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      stab_q <= '0;
    end else begin
      s1_q <= MOD_PIN_I; // R23
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < `CA_NMOD; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          stab_q[i] <= s3_q[i]; // R23
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // pin outputs
  // -----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      pout_q <= '0;
    end else begin
      for (int i = 0; i < `CA_NMOD; i++) begin
        if (role[i] == ROLE_PWM) begin
          pout_q[i] <= (cnt_q[7:0] >= capl_q[i]); // R12
        end else if ((role[i] == ROLE_HSO) && match_ev[i]) begin
          pout_q[i] <= !pout_q[i]; // R9
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `CA_NMOD; i++) begin
      MOD_PIN_OE_O[i] = (role[i] == ROLE_PWM) || (role[i] == ROLE_HSO);
    end
  end
  assign MOD_PIN_O = pout_q;
  assign IRQ_O = |(flag_q & eccf); // R3

  // -----------------------------------------------------------------
  // watchdog on module four
  // -----------------------------------------------------------------
  // internal reset only; there is deliberately no reset pin output
  assign wd_hit = match_ev[`CA_WD_MODULE] && mode_q[`CA_WD_MODULE][`CA_B_MAT]
                  && !pwm_on[`CA_WD_MODULE] && cmode_q[`CA_B_ARRAY_WATCHDOG_ENABLE]; // R16 R17 R19

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      wdrst_q <= 1'b0;
    end else begin
      wdrst_q <= wd_hit; // R18
    end
  end
  assign INT_RST_O = wdrst_q;

  // -----------------------------------------------------------------
  // register read port
  // -----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rdata_q <= `CA_RST_BYTE;
    end else if (!RD_I) begin
      rdata_q <= `CA_RST_BYTE;
    end else if (ADDR_I == `CA_CTRL_ADDR) begin
      rdata_q <= {1'b0, run_q, 1'b0, flag_q};
    end else if (ADDR_I == `CA_CMODE_ADDR) begin
      rdata_q <= cmode_q;
    end else if (ADDR_I == `CA_CL_ADDR) begin
      rdata_q <= cnt_q[7:0];
    end else if (ADDR_I == `CA_CH_ADDR) begin
      rdata_q <= cnt_q[15:8];
    end else if (in_bank(ADDR_I, `CA_MODE_BASE)) begin
      rdata_q <= mode_q[3'(ADDR_I - `CA_MODE_BASE)]; // R8
    end else if (in_bank(ADDR_I, `CA_CAPL_BASE)) begin
      rdata_q <= capl_q[3'(ADDR_I - `CA_CAPL_BASE)];
    end else if (in_bank(ADDR_I, `CA_CAPH_BASE)) begin
      rdata_q <= caph_q[3'(ADDR_I - `CA_CAPH_BASE)];
    end else begin
      rdata_q <= `CA_RST_BYTE;
    end
  end
  assign RDATA_O = rdata_q;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  for (genvar g = 0; g < `CA_NMOD; g++) begin : g_chk
    a_capture_loads: assert property (@(posedge MCLK_I) disable iff (RST_I) // R2
      cap_ev[g] |=> ({caph_q[g], capl_q[g]} == $past(cnt_q)))
      else $error("capture did not load counter");
    a_irq_follows_flag: assert property (@(posedge MCLK_I) disable iff (RST_I) // R3
      (flag_q[g] && eccf[g]) |-> IRQ_O)
      else $error("interrupt missing with flag and enable set");
    a_match_sets_flag: assert property (@(posedge MCLK_I) disable iff (RST_I) // R4
      (match_ev[g] && mode_q[g][`CA_B_MAT] && !pwm_on[g]) |=> flag_q[g])
      else $error("match did not set event flag");
    a_high_sets_comparator_enable: assert property (@(posedge MCLK_I) disable iff (RST_I) // R5
      wr_caph[g] |=> mode_q[g][`CA_B_COMPARATOR_ENABLE])
      else $error("compare high write did not set comparator enable");
    a_low_clears_comparator_enable: assert property (@(posedge MCLK_I) disable iff (RST_I) // R6
      (wr_capl[g] && mode_q[g][`CA_B_COMPARATOR_ENABLE]) |=> !mode_q[g][`CA_B_COMPARATOR_ENABLE])
      else $error("compare low write did not clear comparator enable");
    a_hso_toggles_pin: assert property (@(posedge MCLK_I) disable iff (RST_I) // R9
      (hso_on[g] && match_ev[g]) |=> (MOD_PIN_O[g] != $past(MOD_PIN_O[g])))
      else $error("high-speed output did not toggle");
    a_pwm_level_ok: assert property (@(posedge MCLK_I) disable iff (RST_I) // R12
      pwm_on[g] |=> (MOD_PIN_O[g] == ($past(cnt_q[7:0]) >= $past(capl_q[g]))))
      else $error("pwm level wrong");
    a_pwm_reload_ok: assert property (@(posedge MCLK_I) disable iff (RST_I) // R13
      (pwm_on[g] && wrap && !cap_ev[g] && !wr_capl[g]) |=> (capl_q[g] == $past(caph_q[g])))
      else $error("pwm compare low not reloaded on wrap");
    a_match_only_once: assert property (@(posedge MCLK_I) disable iff (RST_I) // R24
      match_ev[g] |=> !match_ev[g])
      else $error("match acted twice on one counter value");
    a_reload_only_wrap: assert property (@(posedge MCLK_I) disable iff (RST_I) // R13
      (!wrap && !cap_ev[g] && !wr_capl[g]) |=> (capl_q[g] == $past(capl_q[g])))
      else $error("compare low changed outside a wrap");
    a_no_match_off: assert property (@(posedge MCLK_I) disable iff (RST_I) // R4
      !mode_q[g][`CA_B_COMPARATOR_ENABLE] |-> !match_ev[g])
      else $error("match with comparator disabled");
    a_oe_by_mode: assert property (@(posedge MCLK_I) disable iff (RST_I) // R10 R14
      MOD_PIN_OE_O[g] == (mode_q[g][`CA_B_COMPARATOR_ENABLE]
        && (mode_q[g][`CA_B_PWM] || (mode_q[g][`CA_B_TOG] && mode_q[g][`CA_B_MAT]))))
      else $error("pin drive enable disagrees with mode bits");
  end

  a_wd_reset_pulse: assert property (@(posedge MCLK_I) disable iff (RST_I) // R18
    wd_hit |=> INT_RST_O)
    else $error("watchdog match gave no internal reset");
  a_wd_disable_blocks: assert property (@(posedge MCLK_I) disable iff (RST_I) // R19
    !cmode_q[`CA_B_ARRAY_WATCHDOG_ENABLE] |=> !INT_RST_O)
    else $error("watchdog reset while disabled");
  a_counter_steps: assert property (@(posedge MCLK_I) disable iff (RST_I) // R15
    (tick && !wr_cl && !wr_ch) |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("counter did not step on a tick");
  a_counter_holds: assert property (@(posedge MCLK_I) disable iff (RST_I) // R15
    (!tick && !wr_cl && !wr_ch) |=> (cnt_q == $past(cnt_q)))
    else $error("counter moved without a tick");
  a_wd_module_four: assert property (@(posedge MCLK_I) disable iff (RST_I) // R16
    INT_RST_O |-> ($past(match_ev[`CA_WD_MODULE]) && $past(cmode_q[`CA_B_ARRAY_WATCHDOG_ENABLE])))
    else $error("internal reset without a module four match");

endmodule

// *** pin_partner.sv ***
// far-side model of the five module pins
`timescale 1ns/10ps
`include "ca_defines.svh"
module pin_partner (
  input wire logic [`CA_NMOD-1:0] ext_i,
  input wire logic [`CA_NMOD-1:0] drv_i,
  input wire logic [`CA_NMOD-1:0] oe_i,
  output logic [`CA_NMOD-1:0] pin_o
);
  // ---------------------------------------------
  // wire resolution
  // ---------------------------------------------
  // outside driver yields where the module drives, so no contention
  assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule

// *** testbench.sv ***
// self-checking bench for the counter array compare/capture block
`timescale 1ns/10ps
`include "ca_defines.svh"
module testbench;
  import ca_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] ext = 5'h00;
  logic [7:0] rdata;
  logic [4:0] pin_o;
  logic [4:0] pin_oe;
  logic [4:0] pin_i;
  logic irq;
  logic int_rst;
  int err_count = 0;
  int n_tests = 0;
  int rst_pulses = 0;
  // address, write data, read-back
  logic [23:0] rows [8] = '{24'hDAFF7F, 24'hDB4040, 24'hDC3F3F, 24'hEC5A5A,
                            24'hE93C3C, 24'hF9C3C3, 24'hD94F4F, 24'h005500};
  byte_t mcmp [5] = '{8'h10, 8'h05, 8'h05, 8'h00, 8'h08};
  byte_t mmode [5] = '{8'h49, 8'h4C, 8'h44, 8'h00, 8'h48};

  counter_array_compare_capture dut_u (
    .MCLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .MOD_PIN_I(pin_i), .MOD_PIN_O(pin_o),
    .MOD_PIN_OE_O(pin_oe), .IRQ_O(irq), .INT_RST_O(int_rst));
  pin_partner far_u (.ext_i(ext), .drv_i(pin_o), .oe_i(pin_oe), .pin_o(pin_i));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (int_rst === 1'b1) rst_pulses++;
  end

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wr_reg(input byte_t a, input byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input byte_t a, output byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rchk(input byte_t a, input byte_t e);
    byte_t d;
    rd_reg(a, d);
    chk($sformatf("reg_%h", a), {8'h00, e}, {8'h00, d});
  endtask
  // counts cycles from counter start to the first module 0 match
  task automatic run_match(input byte_t cfg, output int n);
    wr_reg(`CA_CTRL_ADDR, 8'h00);
    wr_reg(`CA_CL_ADDR, 8'h00);
    wr_reg(`CA_CH_ADDR, 8'h00);
    wr_reg(`CA_CMODE_ADDR, cfg);
    wr_reg(`CA_CTRL_ADDR, 8'h40);
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 1000) begin
        chk("irq_wait", 16'h0001, {15'h0000, irq});
        summarize();
      end
    end
    rchk(`CA_CTRL_ADDR, 8'h53);
    wr_reg(`CA_CTRL_ADDR, 8'h00);
    #1;
    chk("irq_clear", 16'h0000, {15'h0000, irq});
  endtask
  task automatic cap_step(input byte_t m, input logic [15:0] c, input logic lvl,
                          input logic [15:0] e);
    byte_t lo;
    byte_t hi;
    wr_reg(8'hDD, m);
    wr_reg(`CA_CL_ADDR, c[7:0]);
    wr_reg(`CA_CH_ADDR, c[15:8]);
    ext[3] <= lvl;
    // pin passes the synchroniser before the edge counts
    repeat (8) @(posedge clk);
    rd_reg(8'hED, lo);
    rd_reg(8'hFD, hi);
    chk("capture", e, {hi, lo});
  endtask

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    int t0;
    int t1;
    int hi;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("outs_reset", 16'h0000, {4'h0, pin_o, pin_oe, irq, int_rst});
    for (int i = 0; i < 8; i++) begin
      rchk(rows[i][23:16], 8'h00);
      wr_reg(rows[i][23:16], rows[i][15:8]);
      rchk(rows[i][23:16], rows[i][7:0]);
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(`CA_MODE_BASE, 8'h00);
    rchk(`CA_CMODE_ADDR, 8'h00);
    wr_reg(8'hFD, 8'h00);
    rchk(8'hDD, 8'h40);
    wr_reg(8'hED, 8'h00);
    rchk(8'hDD, 8'h00);
    wr_reg(8'hED, 8'h00);
    rchk(8'hDD, 8'h00);
    wr_reg(8'hDD, 8'h40);
    rchk(8'hDD, 8'h40);
    // low byte first, then high byte, then the mode
    for (int n = 0; n < `CA_NMOD; n++) begin
      wr_reg(`CA_CAPL_BASE + 8'(n), mcmp[n]);
      wr_reg(`CA_CAPH_BASE + 8'(n), 8'h00);
      wr_reg(`CA_MODE_BASE + 8'(n), mmode[n]);
    end
    run_match(8'h00, t0);
    chk("hso_pin", 16'h0001, {14'h0000, pin_o[2:1]});
    chk("hso_oe", 16'h0002, {11'h000, pin_oe});
    chk("wd_off", 16'h0000, 16'(rst_pulses));
    run_match(8'h43, t1);
    chk("step_time", 16'h0030, 16'(t1 - t0));
    chk("hso_pin", 16'h0000, {14'h0000, pin_o[2:1]});
    chk("wd_on", 16'h0001, 16'(rst_pulses));
    cap_step(8'h10, 16'hA5C3, 1'b1, 16'h0000);
    cap_step(8'h30, 16'h1234, 1'b0, 16'h1234);
    cap_step(8'h30, 16'h5678, 1'b1, 16'h5678);
    rchk(`CA_CTRL_ADDR, 8'h08);
    wr_reg(`CA_CTRL_ADDR, 8'h00);
    wr_reg(`CA_CL_ADDR, 8'h00);
    wr_reg(`CA_CH_ADDR, 8'h00);
    wr_reg(`CA_CMODE_ADDR, 8'h00);
    wr_reg(8'hEC, 8'h40);
    wr_reg(8'hFC, 8'hC0);
    wr_reg(8'hDC, 8'h42);
    wr_reg(`CA_CTRL_ADDR, 8'h40);
    #1;
    chk("pwm_oe", 16'h0004, {11'h000, pin_oe & 5'h04});
    // one full low byte period so the reload has happened
    repeat (300) @(posedge clk);
    rchk(8'hEC, 8'hC0);
    hi = 0;
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      #1;
      if (pin_o[2] === 1'b1) hi++;
    end
    chk("pwm_high", 16'h0040, 16'(hi));
    wr_reg(8'hDC, 8'h02);
    #1;
    chk("pwm_oe", 16'h0000, {11'h000, pin_oe & 5'h04});
    wr_reg(`CA_CTRL_ADDR, 8'h00);
    wr_reg(`CA_CL_ADDR, 8'h00);
    wr_reg(`CA_CH_ADDR, 8'h00);
    // a source other than the system clock leaves the counter standing
    wr_reg(`CA_CMODE_ADDR, 8'h10);
    wr_reg(`CA_CTRL_ADDR, 8'h40);
    repeat (20) @(posedge clk);
    rchk(`CA_CL_ADDR, 8'h00);
    wr_reg(`CA_CMODE_ADDR, 8'h4F);
    hi = rst_pulses;
    // keep module four's compare ahead of the slow counter
    for (int k = 1; k <= 8; k++) begin
      repeat (60) @(posedge clk);
      wr_reg(`CA_CAPL_BASE + 8'h04, 8'(8 + 4 * k));
      wr_reg(`CA_CAPH_BASE + 8'h04, 8'h00);
    end
    chk("wd_held", 16'(hi), 16'(rst_pulses));
    repeat (200) @(posedge clk);
    chk("wd_armed", 16'(hi + 1), 16'(rst_pulses));
    wr_reg(`CA_CTRL_ADDR, 8'h00);
    summarize();
  end
endmodule
